// File: bench/spi_forward_fifo_status_bench.sv
// Self-checking bench for the SPI forwarding status block
`define CHK(nm, e, g) begin comparisons++; \
  if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", nm, (e), (g)); end end

module spi_forward_fifo_status_bench
  import fwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic sck, cs_n, mosi, miso;
  logic rx_valid = 1'b0;
  logic [15:0] rx_data = 16'h0000;
  logic ch_valid, ch_last, fault, fault_oe;
  logic ch_ready = 1'b0;
  logic [15:0] ch_data;
  logic [15:0] lfsr = 16'h0046;
  logic [15:0] seed = 16'h0046;
  logic ready_en = 1'b1;
  int err_total = 0;
  int comparisons = 0;
  logic [16:0] exp_q[$];
  logic [15:0] rxq_m[$];
  bit ovf_m, uvf_m, por_m;

  always #2.5 ref_clk = ~ref_clk;

  spi_forward_fifo_status spi_forward_fifo_status_inst (
    .ref_clk_i(ref_clk), .rst_i(rst), .spi_sck_i(sck), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .spi_miso_o(miso), .chain_rx_valid_i(rx_valid),
    .chain_rx_data_i(rx_data), .chain_valid_o(ch_valid),
    .chain_ready_i(ch_ready), .chain_data_o(ch_data),
    .chain_last_o(ch_last), .fault_o(fault), .fault_oe_o(fault_oe));

  spi_host_model spi_host_model_inst (
    .ref_clk_i(ref_clk), .spi_miso_i(miso), .spi_sck_o(sck),
    .spi_cs_n_o(cs_n), .spi_mosi_o(mosi));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                          input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      c = (c[15] ^ w[i]) ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction : crc_upd

  function automatic logic [15:0] rx_stat();
    int n = rxq_m.size();
    return {ovf_m, uvf_m, 6'h00, (n > 255) ? 8'hFF : 8'(n)};
  endfunction : rx_stat

  // ****************************************
  // Chain side: random stalls and word checking
  // ****************************************
  always @(posedge ref_clk) begin
    lfsr <= lfsr_next(lfsr);
    ch_ready <= ready_en & lfsr[3];
  end

  always @(posedge ref_clk) begin
    if (rst === 1'b0 && ch_valid === 1'b1 && ch_ready === 1'b1) begin
      if (por_m || exp_q.size() == 0) begin
        `CHK("forward word", 1'b0, 1'b1)
      end else begin
        `CHK("chain word", exp_q[0], {ch_last, ch_data})
        void'(exp_q.pop_front());
      end
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    exp_q.delete();
    rxq_m.delete();
    ovf_m = 1'b0;
    uvf_m = 1'b0;
    por_m = 1'b1;
    repeat (8) @(posedge ref_clk);
  endtask : do_reset

  task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] r;
    spi_host_model_inst.frame_open();
    spi_host_model_inst.xfer({OP_WR_REG, a}, r);
    spi_host_model_inst.xfer(d, r);
    spi_host_model_inst.frame_close();
  endtask : wr_reg

  task automatic chk_reg(input logic [11:0] a, input logic [15:0] e,
                         input logic [15:0] m);
    logic [15:0] r;
    spi_host_model_inst.frame_open();
    spi_host_model_inst.xfer({OP_RD_REG, a}, r);
    spi_host_model_inst.xfer(16'h0000, r);
    spi_host_model_inst.frame_close();
    `CHK("register", e & m, r & m)
  endtask : chk_reg

  task automatic clear_flags();
    por_m = 1'b0;
    ovf_m = 1'b0;
    uvf_m = 1'b0;
    wr_reg(REG_CTRL, 16'h0001 << CTRL_CLR_BIT);
  endtask : clear_flags

  task automatic fwd(input int n, input bit chk, input bit bad);
    logic [15:0] r, crc;
    crc = CRC_INIT;
    spi_host_model_inst.frame_open();
    spi_host_model_inst.xfer({chk ? OP_FWD_CHK : OP_FWD, 12'(n)}, r);
    for (int i = 0; i < n; i++) begin
      seed = lfsr_next(seed);
      crc = crc_upd(crc, seed);
      spi_host_model_inst.xfer(seed, r);
      if (!bad) exp_q.push_back({i == n - 1, seed});
    end
    if (chk) spi_host_model_inst.xfer(crc ^ {15'h0000, bad}, r);
    spi_host_model_inst.frame_close();
  endtask : fwd

  task automatic push_rx(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      seed = lfsr_next(seed);
      rx_valid <= 1'b1;
      rx_data <= seed;
      if (rxq_m.size() == 256) ovf_m = 1'b1;
      else rxq_m.push_back(seed);
    end
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : push_rx

  task automatic rd_rxq(input int n);
    logic [15:0] r;
    spi_host_model_inst.frame_open();
    spi_host_model_inst.xfer({OP_RD_RXQ, 12'h000}, r);
    for (int i = 0; i < n; i++) begin
      spi_host_model_inst.xfer(16'h0000, r);
      if (rxq_m.size() > 0) begin
        `CHK("receive word", rxq_m.pop_front(), r)
      end else uvf_m = 1'b1;
    end
    spi_host_model_inst.frame_close();
  endtask : rd_rxq

  task automatic drain();
    for (int i = 0; i < 5000 && exp_q.size() > 0; i++) @(posedge ref_clk);
    `CHK("chain backlog", 0, exp_q.size())
    if (exp_q.size() != 0) print_verdict();
  endtask : drain

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_reset();
    `CHK("fault drive", 1'b0, fault)
    `CHK("fault enable", 1'b1, fault_oe)
    chk_reg(REG_STATUS, 16'h0002, 16'h0002);
    chk_reg(REG_RXQ_STATUS, 16'h0000, 16'hFFFF);
    chk_reg(REG_TXQ_STATUS, 16'h0000, 16'h01FF);
    wr_reg(REG_THRESH, 16'h0008);
    chk_reg(REG_THRESH, 16'h0008, 16'h01FF);
    fwd(3, 1'b0, 1'b0);
    for (int i = 0; i < 200; i++) begin
      @(posedge ref_clk);
      `CHK("blocked valid", 1'b0, ch_valid)
    end
    chk_reg(REG_TXQ_STATUS, 16'h0003, 16'h01FF);
    clear_flags();
    drain();
    `CHK("fault enable", 1'b0, fault_oe)
    ready_en <= 1'b0;
    fwd(4, 1'b0, 1'b0);
    fwd(5, 1'b1, 1'b0);
    fwd(2, 1'b0, 1'b0);
    ready_en <= 1'b1;
    drain();
    fwd(4, 1'b1, 1'b1);
    repeat (300) @(posedge ref_clk);
    drain();
    push_rx(254);
    chk_reg(REG_RXQ_STATUS, rx_stat(), 16'hFFFF);
    push_rx(3);
    chk_reg(REG_RXQ_STATUS, rx_stat(), 16'hFFFF);
    `CHK("fault enable", 1'b1, fault_oe)
    chk_reg(REG_RXQ_STATUS, rx_stat(), 16'hFFFF);
    clear_flags();
    chk_reg(REG_RXQ_STATUS, rx_stat(), 16'hFFFF);
    do_reset();
    `CHK("fault enable", 1'b1, fault_oe)
    clear_flags();
    push_rx(2);
    rd_rxq(3);
    chk_reg(REG_RXQ_STATUS, rx_stat(), 16'hFFFF);
    print_verdict();
  end
endmodule : spi_forward_fifo_status_bench

// File: bench/spi_host_model.sv
// Mode 0 SPI host model that drives commands into the status block
module spi_host_model (
  input wire logic ref_clk_i,
  input wire logic spi_miso_i,
  output logic spi_sck_o,
  output logic spi_cs_n_o,
  output logic spi_mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    spi_sck_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // Half of an 80 ns link period
  task automatic half();
    repeat (8) @(posedge ref_clk_i);
  endtask : half

  task automatic frame_open();
    @(posedge ref_clk_i);
    spi_cs_n_o <= 1'b0;
    half();
  endtask : frame_open

  // Released data line shows the inverse so a stale level is never trusted
  task automatic frame_close();
    half();
    spi_cs_n_o <= 1'b1;
    spi_mosi_o <= ~spi_mosi_o;
    half();
  endtask : frame_close

  // Clock stands low outside frames; miso sampled at the rising sck edge,
  // before the block reloads its shifter at the end of a word
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi_o <= tx[i];
      half();
      rx[i] = spi_miso_i;
      spi_sck_o <= 1'b1;
      half();
      spi_sck_o <= 1'b0;
    end
  endtask : xfer
endmodule : spi_host_model

// File: hw/fwd_pkg.sv
// Shared constants for the SPI forwarding bridge status block
package fwd_pkg;
  // ****************************************
  // Register map (word addresses)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] REG_TXQ_STATUS = 12'h009;
  localparam logic [11:0] REG_RXQ_STATUS = 12'h00A;
  localparam logic [11:0] REG_CTRL = 12'h010;
  localparam logic [11:0] REG_THRESH = 12'h011;
  localparam logic [11:0] REG_STATUS = 12'h012;
  localparam int RXQ_OVF_BIT = 15;
  localparam int RXQ_UVF_BIT = 14;
  localparam int RXQ_SED_BIT = 13;
  localparam int TXQ_OVF_BIT = 15;
  localparam int CTRL_CLR_BIT = 0;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_POR_BIT = 1;
  localparam int STAT_QFULL_BIT = 2;
  localparam int STAT_QOVF_BIT = 3;
  localparam logic [8:0] THRESH_RESET = 9'h010;
  // ****************************************
  // Queue geometry
  // ****************************************
  localparam int WORD_W = 16;
  localparam int RXQ_AW = 8;
  localparam int TXQ_AW = 9;
  localparam int CMDQ_DEPTH = 4;
  localparam int CMDQ_W = 13;
  localparam logic [7:0] RXQ_LVL_MAX = 8'hFF;
  localparam logic [8:0] TXQ_LVL_MAX = 9'h1FF;
  // ****************************************
  // Command words: op in [15:12], address or length in [11:0]
  // ****************************************
  localparam logic [3:0] OP_WR_REG = 4'h1;
  localparam logic [3:0] OP_RD_REG = 4'h2;
  localparam logic [3:0] OP_FWD = 4'h3;
  localparam logic [3:0] OP_FWD_CHK = 4'h4;
  localparam logic [3:0] OP_RD_RXQ = 4'h5;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  typedef enum logic [2:0] {
    ST_CMD, ST_WDATA, ST_RDATA, ST_FWD, ST_FWDC, ST_CHK, ST_RXQ, ST_SKIP
  } spi_state_t;
endpackage : fwd_pkg

// File: hw/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule : pin_sync

// File: hw/spi_forward_fifo_status.sv
// SPI register port, forwarding queues and receive queue status
// Notes on behaviour
// [RULE_01] Write into full receive queue sets bit 15
// [RULE_02] Read from empty receive queue sets bit 14
// [RULE_03] Parity mismatch on receive read sets bit 13
// [RULE_04] Receive level in bits 7-0, saturates at FF
// [RULE_05] Host sets threshold above longest chain command
// [RULE_06] Checked forward waits for good checksum, no threshold
// [RULE_07] Forward commands wait in a command queue
// [RULE_08] Power-on flag blocks forwarding until host clears
// [RULE_09] Host waits for Normal state before setup
// [RULE_10] Fault pin pulled low while any error
// [RULE_11] Transmit level in bits 8-0, saturates at 1FF
// [RULE_12] Error flags sticky until clear; bits 12-8 zero
module spi_forward_fifo_status
  import fwd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  input wire logic chain_rx_valid_i,
  input wire logic [15:0] chain_rx_data_i,
  output logic chain_valid_o,
  input wire logic chain_ready_i,
  output logic [15:0] chain_data_o,
  output logic chain_last_o,
  output logic fault_o,
  output logic fault_oe_o
);
  // ****************************************
  // Pin sampling and SPI word assembly
  // ****************************************
  logic [2:0] pins_s;
  logic sck_s, cs_n_s, mosi_s, sck_d_reg;
  logic sck_rise, sck_fall, word_done;
  logic [3:0] bit_cnt_reg;
  logic [15:0] in_sr_reg, out_sr_reg, word;

  pin_sync #(.WIDTH(3)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i({spi_sck_i, spi_cs_n_i, spi_mosi_i}),
    .sync_o(pins_s)
  );
  assign {sck_s, cs_n_s, mosi_s} = pins_s;
  assign sck_rise = sck_s & ~sck_d_reg & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_reg & ~cs_n_s;
  assign word_done = sck_rise && (bit_cnt_reg == 4'hF);
  assign word = {in_sr_reg[14:0], mosi_s};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sck_d_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      in_sr_reg <= 16'h0000;
    end else begin
      sck_d_reg <= sck_s;
      if (cs_n_s) begin
        bit_cnt_reg <= 4'h0;
      end else if (sck_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        in_sr_reg <= word;
      end
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  spi_state_t state_reg, state_next;
  logic [11:0] addr_reg, left_reg;
  logic [15:0] crc_reg;
  logic [TXQ_AW:0] tx_wr_reg, tx_rd_reg, tx_mark_reg;
  logic tx_push, rxq_pop, reg_wr, chk_good, chk_bad, plain_hdr;
  logic [3:0] op;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [15:0] d);
    logic [15:0] r;
    r = c ^ d;
    for (int i = 0; i < 16; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction : crc_step

  assign op = word[15:12];

  always_comb begin
    state_next = state_reg;
    tx_push = 1'b0;
    rxq_pop = 1'b0;
    reg_wr = 1'b0;
    chk_good = 1'b0;
    chk_bad = 1'b0;
    plain_hdr = 1'b0;
    if (cs_n_s) begin
      state_next = ST_CMD;
      chk_bad = (state_reg == ST_FWDC) || (state_reg == ST_CHK);
    end else if (word_done) begin
      case (state_reg)
        ST_CMD: begin
          case (op)
            OP_WR_REG: state_next = ST_WDATA;
            OP_RD_REG: state_next = ST_RDATA;
            OP_FWD: begin
              plain_hdr = (word[11:0] != 12'h000);
              state_next = plain_hdr ? ST_FWD : ST_CMD;
            end
            OP_FWD_CHK: state_next = (word[11:0] != 12'h000) ? ST_FWDC : ST_CMD;
            OP_RD_RXQ: begin
              rxq_pop = 1'b1;
              state_next = ST_RXQ;
            end
            default: state_next = ST_SKIP;
          endcase
        end
        ST_WDATA: begin
          reg_wr = 1'b1;
          state_next = ST_CMD;
        end
        ST_FWD: begin
          tx_push = 1'b1;
          state_next = (left_reg == 12'h001) ? ST_CMD : ST_FWD;
        end
        ST_FWDC: begin
          tx_push = 1'b1;
          state_next = (left_reg == 12'h001) ? ST_CHK : ST_FWDC;
        end
        ST_CHK: begin
          chk_good = (word == crc_reg); // RULE_06
          chk_bad = (word != crc_reg); // RULE_06
          state_next = ST_CMD;
        end
        ST_RXQ: rxq_pop = 1'b1;
        ST_RDATA: state_next = ST_CMD;
        default: state_next = state_reg;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_CMD;
      addr_reg <= 12'h000;
      left_reg <= 12'h000;
      crc_reg <= CRC_INIT;
    end else begin
      state_reg <= state_next;
      if (word_done && state_reg == ST_CMD) begin
        addr_reg <= word[11:0];
        left_reg <= word[11:0];
        crc_reg <= CRC_INIT;
      end else if (tx_push) begin
        left_reg <= left_reg - 12'h001;
        crc_reg <= crc_step(crc_reg, word);
      end
    end
  end

  // ****************************************
  // Control registers and sticky flags
  // ****************************************
  logic por_reg, rx_ovf_reg, rx_uvf_reg, rx_sed_reg, tx_ovf_reg, q_ovf_reg;
  logic clr, err_reg;
  logic [8:0] thresh_reg;
  logic [RXQ_AW:0] rx_wr_reg, rx_rd_reg, rx_count;
  logic [TXQ_AW:0] tx_count;
  logic rx_full, rx_empty, tx_full, rx_push_ok, rx_bad_parity;
  logic [16:0] rxq_mem [2**RXQ_AW];
  logic [15:0] txq_mem [2**TXQ_AW];
  logic [7:0] rx_level;
  logic [8:0] tx_level;
  logic pend_reg, q_ready;

  assign clr = reg_wr && addr_reg == REG_CTRL && word[CTRL_CLR_BIT];
  assign rx_count = rx_wr_reg - rx_rd_reg;
  assign tx_count = tx_wr_reg - tx_rd_reg;
  assign rx_full = rx_count[RXQ_AW];
  assign rx_empty = (rx_count == '0);
  assign tx_full = tx_count[TXQ_AW];
  assign rx_push_ok = chain_rx_valid_i && !rx_full;
  assign rx_bad_parity = ^rxq_mem[rx_rd_reg[RXQ_AW-1:0]];
  assign rx_level = rx_full ? RXQ_LVL_MAX : rx_count[7:0]; // RULE_04
  assign tx_level = tx_full ? TXQ_LVL_MAX : tx_count[8:0]; // RULE_11

  // Hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_ovf_reg <= 1'b0;
      rx_uvf_reg <= 1'b0;
      rx_sed_reg <= 1'b0;
      tx_ovf_reg <= 1'b0;
      q_ovf_reg <= 1'b0;
    end else begin
      rx_ovf_reg <= (chain_rx_valid_i && rx_full) | (rx_ovf_reg & ~clr); // RULE_01 RULE_12
      rx_uvf_reg <= (rxq_pop && rx_empty) | (rx_uvf_reg & ~clr); // RULE_02 RULE_12
      rx_sed_reg <= (rxq_pop && !rx_empty && rx_bad_parity)
                    | (rx_sed_reg & ~clr); // RULE_03 RULE_12
      tx_ovf_reg <= (tx_push && tx_full) | (tx_ovf_reg & ~clr);
      q_ovf_reg <= (pend_reg && !q_ready && (plain_hdr || chk_good))
                   | (q_ovf_reg & ~clr);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      por_reg <= 1'b1;
      thresh_reg <= THRESH_RESET;
    end else begin
      if (clr) begin
        por_reg <= 1'b0; // RULE_08
      end
      if (reg_wr && addr_reg == REG_THRESH) begin
        thresh_reg <= word[8:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_reg <= 1'b1;
    end else begin
      err_reg <= por_reg | rx_ovf_reg | rx_uvf_reg | rx_sed_reg
                 | tx_ovf_reg | q_ovf_reg;
    end
  end
  assign fault_o = 1'b0; // RULE_10
  assign fault_oe_o = err_reg; // RULE_10

  // ****************************************
  // Receive queue: chain in, SPI out, parity protected
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
    end else begin
      if (rx_push_ok) begin
        rx_wr_reg <= rx_wr_reg + 1'b1;
      end
      if (rxq_pop && !rx_empty) begin
        rx_rd_reg <= rx_rd_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rx_push_ok) begin
      rxq_mem[rx_wr_reg[RXQ_AW-1:0]] <= {^chain_rx_data_i, chain_rx_data_i};
    end
  end

  // ****************************************
  // Transmit queue with rollback of unchecked payload
  // ****************************************
  logic start, chain_pop;
  logic [11:0] fwd_left_reg;
  logic [CMDQ_W-1:0] pend_data_reg, head;
  logic head_valid;

  assign chain_pop = chain_valid_o && chain_ready_i;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_mark_reg <= '0;
    end else begin
      if (word_done && state_reg == ST_CMD) begin
        tx_mark_reg <= tx_wr_reg;
      end
      if (chk_bad) begin
        tx_wr_reg <= tx_mark_reg; // RULE_06
      end else if (tx_push && !tx_full) begin
        tx_wr_reg <= tx_wr_reg + 1'b1;
      end
      if (chain_pop) begin
        tx_rd_reg <= tx_rd_reg + 1'b1;
      end
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (tx_push && !tx_full) begin
      txq_mem[tx_wr_reg[TXQ_AW-1:0]] <= word;
    end
  end

  // ****************************************
  // Command queue and chain forwarding
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_reg <= 1'b0;
      pend_data_reg <= '0;
    end else if (plain_hdr || chk_good) begin
      pend_reg <= 1'b1; // RULE_07
      pend_data_reg <= plain_hdr ? {1'b0, word[11:0]} : {1'b1, addr_reg};
    end else if (q_ready) begin
      pend_reg <= 1'b0;
    end
  end

  word_fifo #(.WIDTH(CMDQ_W), .DEPTH(CMDQ_DEPTH)) u_cmdq (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(pend_reg),
    .in_ready_o(q_ready),
    .in_data_i(pend_data_reg),
    .out_valid_o(head_valid),
    .out_ready_i(start),
    .out_data_o(head)
  );

  // Plain commands start past the threshold or once fully received
  assign start = head_valid && !por_reg && fwd_left_reg == 12'h000
                 && (head[12] || tx_count > {1'b0, thresh_reg}
                     || state_reg != ST_FWD); // RULE_08 RULE_06
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fwd_left_reg <= 12'h000;
    end else if (start) begin
      fwd_left_reg <= head[11:0];
    end else if (chain_pop) begin
      fwd_left_reg <= fwd_left_reg - 12'h001;
    end
  end
  assign chain_valid_o = (fwd_left_reg != 12'h000) && (tx_count != '0);
  assign chain_data_o = txq_mem[tx_rd_reg[TXQ_AW-1:0]];
  assign chain_last_o = (fwd_left_reg == 12'h001);

  // ****************************************
  // Register read and MISO shifter
  // ****************************************
  logic [15:0] rd_data;
  always_comb begin
    case (word[11:0])
      REG_RXQ_STATUS: rd_data = {rx_ovf_reg, rx_uvf_reg, rx_sed_reg,
                                 5'h00, rx_level}; // RULE_12
      REG_TXQ_STATUS: rd_data = {tx_ovf_reg, 6'h00, tx_level};
      REG_THRESH: rd_data = {7'h00, thresh_reg};
      REG_STATUS: rd_data = {12'h000, q_ovf_reg, ~q_ready, por_reg, err_reg};
      default: rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_sr_reg <= 16'h0000;
    end else if (word_done && state_reg == ST_CMD && op == OP_RD_REG) begin
      out_sr_reg <= rd_data;
    end else if (rxq_pop) begin
      out_sr_reg <= rx_empty ? 16'h0000 : rxq_mem[rx_rd_reg[RXQ_AW-1:0]][15:0];
    end else if (word_done) begin
      out_sr_reg <= 16'h0000;
    end else if (sck_fall && bit_cnt_reg != 4'h0) begin
      out_sr_reg <= {out_sr_reg[14:0], 1'b0};
    end
  end
  assign spi_miso_o = out_sr_reg[15];

  // ****************************************
  // Checks
  // ****************************************
  sequence s_push_full;
    chain_rx_valid_i && rx_full;
  endsequence
  sequence s_pop_empty;
    rxq_pop && rx_empty;
  endsequence

  AST_RX_OVF: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_01
    s_push_full |=> rx_ovf_reg && rx_wr_reg == $past(rx_wr_reg))
    else $error("overflow not flagged");
  AST_RX_UVF: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_02
    s_pop_empty |=> rx_uvf_reg && out_sr_reg == 16'h0000)
    else $error("underflow not flagged");
  AST_RX_SED: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_03
    rxq_pop && !rx_empty && rx_bad_parity |=> rx_sed_reg)
    else $error("storage error not flagged");
  AST_RX_LEVEL: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_04
    rx_count >= 9'd255 |-> rx_level == 8'hFF)
    else $error("receive level not saturated");
  AST_TX_LEVEL: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_11
    tx_count < 10'd511 |-> tx_level == tx_count[8:0])
    else $error("transmit level wrong");
  AST_CHK_ROLLBACK: assert property (@(posedge ref_clk_i) // RULE_06
    disable iff (rst_i) chk_bad |=> tx_wr_reg == $past(tx_mark_reg) && !pend_reg)
    else $error("bad checksum payload kept");
  AST_POR_BLOCK: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_08
    por_reg |-> !start && fwd_left_reg == 12'h000)
    else $error("forwarding while power-on flag set");
  AST_STICKY: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_12
    rx_ovf_reg && !clr |=> rx_ovf_reg [*2] or clr)
    else $error("flag dropped without clear");
  AST_CMD_QUEUE: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_07
    pend_reg && q_ready && !plain_hdr && !chk_good |=> !pend_reg)
    else $error("command not queued");
  AST_FAULT: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
    s_push_full |=> ##1 fault_oe_o && !fault_o)
    else $error("fault pin not asserted");
endmodule : spi_forward_fifo_status

// File: hw/word_fifo.sv
// Small valid/ready FIFO with parameter width and depth
module word_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_reg;
  logic [AW:0] rd_reg;
  logic full;
  logic empty;

  assign empty = (wr_reg == rd_reg);
  assign full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = mem_reg[rd_reg[AW-1:0]];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_reg <= '0;
    end else if (in_valid_i && !full) begin
      wr_reg <= wr_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (in_valid_i && !full) begin
      mem_reg[wr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_reg <= '0;
    end else if (out_ready_i && !empty) begin
      rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule : word_fifo
